// ### verilog/octal_switch_regs.vh
// Constants for the octal switch serial control block
`ifndef OCTAL_SWITCH_REGS_VH
`define OCTAL_SWITCH_REGS_VH

`define FRAME_BITS 8
`define CMD_RESET 8'h00
`define FLT_RESET 8'h00
// Update timeout, least value, in microseconds
`define TIMEOUT_US 272
// Internal refresh interval, in nanoseconds (15 kHz refresh)
`define REFRESH_NS 66667
// Supply-good refresh ceiling, in microseconds
`define SUPPLY_REFRESH_US 120
`define CLK_NS 25
`define TIMEOUT_CYCLES ((`TIMEOUT_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define REFRESH_CYCLES (`REFRESH_NS / `CLK_NS)
// Minimum output-enable low width, in nanoseconds
`define OE_MIN_NS 1000
`define OE_MIN_CYCLES ((`OE_MIN_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ### verilog/pin_sync.v
// Two-flop synchroniser for a bundle of asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] IDLE = {WIDTH{1'b0}}
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Pins in, synchronised levels out
	input wire [WIDTH-1:0] pin_in,
	output reg [WIDTH-1:0] level_out
);

reg [WIDTH-1:0] stage1;

always @(posedge core_clk) begin
	if (rst) begin
		// Reset to the pins' idle levels so no false edge follows reset
		stage1 <= IDLE;
		level_out <= IDLE;
	end else begin
		stage1 <= pin_in;
		level_out <= stage1;
	end
end

endmodule

`default_nettype wire

// ### verilog/update_watchdog.v
// Output-stage timeout counter: expires when no update arrives in time
`timescale 1ns/1ps
`default_nettype none

module update_watchdog #(
	parameter COUNT = 10880,
	parameter WIDTH = 16
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Update strobe in, expiry level out
	input wire kick,
	output reg expired
);

reg [WIDTH-1:0] count;

always @(posedge core_clk) begin
	if (rst) begin
		count <= {WIDTH{1'b0}};
		expired <= 1'b0;
	end else if (kick) begin
		count <= {WIDTH{1'b0}};
		expired <= 1'b0;
	end else if (count >= COUNT[WIDTH-1:0] - 1'b1) begin
		expired <= 1'b1;
	end else begin
		count <= count + 1'b1;
	end
end

endmodule

`default_nettype wire

// ### verilog/octal_switch_spi_control.v
// Serial control, watchdog and fault logic of an eight-channel switch
`timescale 1ns/1ps
`default_nettype none
`include "octal_switch_regs.vh"

// What this block does
// - Eight-bit frames, channel seven sent first
// - Fault frame, one bit per channel, one=fault
// - Input sampled on serial clock rising edges
// - Output changes on serial clock falling edges
// - First fault bit driven when select falls
// - Serial output released while select and enable high
// - Shift only while select is low
// - Select fall captures faults, pauses refresh
// - Select rise applies received command bits
// - Longer streams: last eight applied, rest passed
// - Chained bits leave after eighth clock
// - Transaction end updates outputs, restarts timeout
// - Timeout without update switches outputs off
// - Periodic refresh also restarts the timeout
// - Output enable low clears, forces off, output low
// - After enable, outputs off until new command
// - Fault when bit count not multiple of eight
// - Transfer error flags fault, keeps outputs
// - Overheated channel flags fault, switches off
// - Supply-good not refreshed while selected
// - Thermal status updated at transfers and refreshes
module octal_switch_spi_control #(
	parameter TIMEOUT_CYCLES = `TIMEOUT_CYCLES,
	parameter REFRESH_CYCLES = `REFRESH_CYCLES,
	parameter OE_MIN_CYCLES = `OE_MIN_CYCLES
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Serial link pins
	input wire sclk,
	input wire select_n,
	input wire sdi,
	output reg sdo,
	output reg sdo_oe,
	// Output enable pin
	input wire out_enable,
	// Process-stage status inputs
	input wire [7:0] overheat_diag,
	input wire undervoltage_lockout,
	input wire transfer_error,
	// Power outputs
	output reg [7:0] switch_on,
	// Open-drain indications
	output wire fault_n_out,
	output wire fault_n_oe,
	output wire supply_ok_flag_out,
	output wire supply_ok_flag_oe
);

// ==========================================================
// Pin synchronisation
wire [3:0] synced;
// Idle levels: enable high, data low, select high, clock low
pin_sync #(.WIDTH(4), .IDLE(4'hA)) u_sync (
	.core_clk(core_clk),
	.rst(rst),
	.pin_in({out_enable, sdi, select_n, sclk}),
	.level_out(synced)
);
wire sclk_s = synced[0];
wire sel_n_s = synced[1];
wire sdi_s = synced[2];
wire oe_s = synced[3];

reg sclk_d;
reg sel_n_d;
always @(posedge core_clk) begin
	if (rst) begin
		sclk_d <= 1'b0;
		sel_n_d <= 1'b1;
	end else begin
		sclk_d <= sclk_s;
		sel_n_d <= sel_n_s;
	end
end

// ==========================================================
// Edge and limit helpers
function edge_up;
	input prev;
	input now;
	begin
		edge_up = ~prev & now;
	end
endfunction

function edge_down;
	input prev;
	input now;
	begin
		edge_down = prev & ~now;
	end
endfunction

// True on the last cycle of a span of limit cycles
function at_limit;
	input [31:0] count;
	input [31:0] limit;
	begin
		at_limit = (count >= limit - 32'h00000001);
	end
endfunction

wire selected = ~sel_n_s;
wire sel_fall = edge_down(sel_n_d, sel_n_s);
wire sel_rise = edge_up(sel_n_d, sel_n_s);
wire sclk_rise = edge_up(sclk_d, sclk_s) & selected;
wire sclk_fall = edge_down(sclk_d, sclk_s) & selected;

// ==========================================================
// Output-enable width filter
reg [15:0] oe_low_count;
reg oe_active;
always @(posedge core_clk) begin
	if (rst) begin
		oe_low_count <= 16'h0000;
		oe_active <= 1'b0;
	end else if (oe_s) begin
		oe_low_count <= 16'h0000;
		oe_active <= 1'b0;
	end else if (at_limit({16'h0000, oe_low_count}, OE_MIN_CYCLES)) begin
		oe_active <= 1'b1;
	end else begin
		oe_low_count <= oe_low_count + 16'h0001;
	end
end

// ==========================================================
// Shift path: fault bits then command bits out, command bits in
reg [7:0] cmd_shift;
reg [7:0] flt_shift;
reg [7:0] fault_reg;
reg [7:0] thermal_status;
reg [2:0] bit_count;
reg out_bit;

// ==========================================================
// Link phase: fault bits for the first seven falls, chained bits after
localparam LINK_IDLE = 2'b00;
localparam LINK_FAULT = 2'b01;
localparam LINK_CHAIN = 2'b10;
localparam LINK_HELD = 2'b11;

reg [1:0] link_state;
reg [1:0] next_link_state;
reg [2:0] fall_count;
reg [2:0] next_fall_count;

always @* begin
	next_link_state = link_state;
	next_fall_count = fall_count;
	case (link_state)
		LINK_IDLE: begin
			if (sel_fall) begin
				next_link_state = LINK_FAULT;
				next_fall_count = 3'h0;
			end
		end
		LINK_FAULT: begin
			if (~selected) begin
				next_link_state = LINK_IDLE;
			end else if (sclk_fall) begin
				next_fall_count = fall_count + 3'h1;
				if (fall_count == 3'h6) begin
					next_link_state = LINK_CHAIN;
				end
			end
		end
		LINK_CHAIN: begin
			if (~selected) begin
				next_link_state = LINK_IDLE;
			end
		end
		LINK_HELD: begin
			if (~oe_active) begin
				next_link_state = LINK_IDLE;
			end
		end
		default: begin
			next_link_state = LINK_IDLE;
		end
	endcase
	if (oe_active) begin
		next_link_state = LINK_HELD;
	end
end

always @(posedge core_clk) begin
	if (rst) begin
		link_state <= LINK_IDLE;
		fall_count <= 3'h0;
	end else begin
		link_state <= next_link_state;
		fall_count <= next_fall_count;
	end
end

always @(posedge core_clk) begin
	if (rst) begin
		cmd_shift <= `CMD_RESET;
		flt_shift <= `FLT_RESET;
		fault_reg <= `FLT_RESET;
		bit_count <= 3'h0;
		out_bit <= 1'b0;
	end else if (oe_active) begin
		cmd_shift <= `CMD_RESET;
		bit_count <= 3'h0;
		out_bit <= 1'b0;
	end else if (sel_fall) begin
		fault_reg <= thermal_status;
		flt_shift <= {thermal_status[6:0], 1'b0};
		out_bit <= thermal_status[7];
		bit_count <= 3'h0;
	end else begin
		if (sclk_rise) begin
			cmd_shift <= {cmd_shift[6:0], sdi_s};
			bit_count <= bit_count + 3'h1;
		end
		if (sclk_fall) begin
			// Fault bits leave first; from the eighth fall the command bits follow
			if (link_state == LINK_FAULT) begin
				out_bit <= flt_shift[7];
			end else begin
				out_bit <= cmd_shift[7];
			end
			flt_shift <= {flt_shift[6:0], 1'b0};
		end
	end
end

always @(posedge core_clk) begin
	if (rst) begin
		sdo <= 1'b0;
		sdo_oe <= 1'b0;
	end else begin
		sdo_oe <= selected | oe_active;
		sdo <= oe_active ? 1'b0 : out_bit;
	end
end

// ==========================================================
// Inter-stage transfer, refresh and watchdog
reg [7:0] applied_cmd;
reg [7:0] staged_cmd;
reg frame_error;
reg [31:0] refresh_count;
// Refresh is held off while selected, so a long selection lets the watchdog expire
wire refresh_tick = at_limit(refresh_count, REFRESH_CYCLES) & ~selected;
wire spi_update = sel_rise & ~oe_active;
wire stage_update = (spi_update | refresh_tick) & ~transfer_error;
wire wd_expired;

always @(posedge core_clk) begin
	if (rst) begin
		refresh_count <= 32'h00000000;
	end else if (selected | refresh_tick) begin
		refresh_count <= 32'h00000000;
	end else begin
		refresh_count <= refresh_count + 32'h00000001;
	end
end

update_watchdog #(.COUNT(TIMEOUT_CYCLES), .WIDTH(16)) u_wd (
	.core_clk(core_clk),
	.rst(rst),
	.kick(stage_update),
	.expired(wd_expired)
);

always @(posedge core_clk) begin
	if (rst) begin
		applied_cmd <= `CMD_RESET;
		staged_cmd <= `CMD_RESET;
		frame_error <= 1'b0;
		thermal_status <= `FLT_RESET;
	end else begin
		if (oe_active) begin
			applied_cmd <= `CMD_RESET;
			staged_cmd <= `CMD_RESET;
		end else if (spi_update & ~transfer_error) begin
			applied_cmd <= cmd_shift;
			staged_cmd <= cmd_shift;
		end else if (refresh_tick & ~transfer_error) begin
			applied_cmd <= staged_cmd;
		end
		if (spi_update) begin
			frame_error <= (bit_count != 3'h0);
		end
		if (stage_update) begin
			thermal_status <= overheat_diag;
		end
	end
end

reg supply_low;
always @(posedge core_clk) begin
	if (rst) begin
		supply_low <= 1'b0;
	end else if (stage_update) begin
		supply_low <= undervoltage_lockout;
	end
end

always @(posedge core_clk) begin
	if (rst) begin
		switch_on <= 8'h00;
	end else if (oe_active | wd_expired) begin
		switch_on <= 8'h00;
	end else begin
		switch_on <= applied_cmd & ~overheat_diag;
	end
end

// ==========================================================
// Open-drain indications, driven low when active
wire thermal_fault = |(thermal_status & applied_cmd);
wire link_fault = frame_error | transfer_error;

reg fault_any;
always @(posedge core_clk) begin
	if (rst) begin
		fault_any <= 1'b0;
	end else begin
		fault_any <= thermal_fault | link_fault;
	end
end

assign fault_n_out = 1'b0;
assign fault_n_oe = fault_any;
assign supply_ok_flag_out = 1'b0;
assign supply_ok_flag_oe = supply_low;

endmodule

`default_nettype wire

// ### tb/osc_sva.sv
// Checker for the octal switch serial control block
`timescale 1ns/1ps
`default_nettype none
module osc_sva #(
	parameter TIMEOUT_CYCLES = 200, REFRESH_CYCLES = 50, OE_MIN_CYCLES = 40
) (
	// Watched ports
	input wire logic core_clk, rst, select_n, out_enable, transfer_error, undervoltage_lockout,
	input wire logic [7:0] overheat_diag, switch_on,
	input wire logic sdo, sdo_oe, fault_n_oe, supply_ok_flag_oe
);
	// ==========
	// Hold-time counters
	int nsel, noe, nuv;
	always @(posedge core_clk) begin
		nsel <= (rst || select_n) ? 0 : nsel + 1;
		noe <= (rst || out_enable) ? 0 : noe + 1;
		nuv <= (rst || !select_n || !undervoltage_lockout) ? 0 : nuv + 1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_idle_off: assert property ((select_n && out_enable)[*5] |-> !sdo_oe) else $error("oe");
	a_sel_drive: assert property ((!select_n)[*5] |-> sdo_oe) else $error("sel");
	a_oe_force: assert property (noe > OE_MIN_CYCLES + 6 |-> !switch_on && !sdo) else $error("oe");
	a_wd_off: assert property (nsel > TIMEOUT_CYCLES + 8 |-> switch_on == 8'h00) else $error("wd");
	a_heat_off: assert property ((switch_on & $past(overheat_diag) & $past(overheat_diag, 2)) == 8'h00)
		else $error("heat");
	a_err_flag: assert property (transfer_error[*2] |-> fault_n_oe) else $error("err");
	a_err_keep: assert property (transfer_error[*3] |=> !(switch_on & ~$past(switch_on)))
		else $error("keep");
	a_uv_flag: assert property (nuv > REFRESH_CYCLES + 10 |-> supply_ok_flag_oe) else $error("uv");
endmodule
bind octal_switch_spi_control osc_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
	.REFRESH_CYCLES(REFRESH_CYCLES), .OE_MIN_CYCLES(OE_MIN_CYCLES)) u_sva(.core_clk(core_clk),
	.rst(rst), .select_n(select_n), .out_enable(out_enable), .transfer_error(transfer_error),
	.undervoltage_lockout(undervoltage_lockout), .overheat_diag(overheat_diag),
	.switch_on(switch_on), .sdo(sdo), .sdo_oe(sdo_oe), .fault_n_oe(fault_n_oe),
	.supply_ok_flag_oe(supply_ok_flag_oe));
`default_nettype wire

// ### tb/spi_host.sv
// Host model: mode-0 serial master, 200 ns clock
`timescale 1ns/1ps
`default_nettype none
module spi_host (
	// Link
	input wire logic core_clk,
	input wire logic miso,
	output logic sclk,
	output logic ss_n,
	output logic mosi
);
	// ==========
	// Clock idles low while deselected
	initial begin
		sclk = 0;
		ss_n = 1;
		mosi = 0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// MSB first; data moves on falls, sampled on rises
	task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] q);
		cyc(1);
		q = 0;
		ss_n = 0;
		mosi = d[n-1];
		cyc(6);
		for (int i = n - 1; i >= 0; i--) begin
			q = {q[30:0], miso};
			sclk = 1;
			cyc(3);
			sclk = 0;
			mosi = (i > 0) ? d[i-1] : ~mosi;
			cyc(5);
		end
		ss_n = 1;
		cyc(10);
	endtask
	task automatic hold(input int n);
		cyc(1);
		ss_n = 0;
		cyc(n);
		ss_n = 1;
		cyc(10);
	endtask
endmodule
`default_nettype wire

// ### tb/octal_switch_spi_control_tb.sv
// Testbench for the octal switch serial control block
`timescale 1ns/1ps
`default_nettype none
module octal_switch_spi_control_tb;
	logic core_clk = 0, rst = 1, out_enable = 1, undervoltage_lockout = 0, transfer_error = 0;
	logic [7:0] overheat_diag = 8'h00;
	logic [31:0] lfsr = 32'h8C7A, q;
	int n_errors = 0, check_count = 0;
	wire sclk, select_n, sdi, sdo, sdo_oe, fault_n_out, fault_n_oe;
	wire supply_ok_flag_out, supply_ok_flag_oe;
	wire [7:0] switch_on;
	wire sdo_line = sdo_oe ? sdo : 1'bz;
	initial forever #12.5 core_clk = ~core_clk;
	octal_switch_spi_control #(.TIMEOUT_CYCLES(200), .REFRESH_CYCLES(50), .OE_MIN_CYCLES(40)) DUT(
		.core_clk(core_clk), .rst(rst), .sclk(sclk), .select_n(select_n), .sdi(sdi),
		.sdo(sdo), .sdo_oe(sdo_oe), .out_enable(out_enable), .overheat_diag(overheat_diag),
		.undervoltage_lockout(undervoltage_lockout), .transfer_error(transfer_error),
		.switch_on(switch_on), .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe),
		.supply_ok_flag_out(supply_ok_flag_out), .supply_ok_flag_oe(supply_ok_flag_oe));
	spi_host u_host(.core_clk(core_clk), .miso(sdo_line), .sclk(sclk), .ss_n(select_n),
		.mosi(sdi));
	// ==========
	// Helpers
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		conclude;
	end
	initial begin
		cyc(20);
		rst = 0;
		cyc(4);
		chk("sw", 0, switch_on);
		chk("oe", 0, sdo_oe);
		for (int k = 0; k < 6; k++) begin
			lfsr = nx(lfsr);
			overheat_diag = lfsr[15:8] & lfsr[23:16];
			cyc(60);
			u_host.xfer(8, lfsr, q);
			cyc(8);
			chk("flt", overheat_diag, q[7:0]);
			chk("sw", lfsr[7:0] & ~overheat_diag, switch_on);
			chk("fpin", |(lfsr[7:0] & overheat_diag), fault_n_oe);
		end
		overheat_diag = 8'h24;
		cyc(60);
		u_host.xfer(16, 32'hC35A, q);
		cyc(8);
		chk("chain", 16'h24C3, q[15:0]);
		chk("sw", 8'h5A, switch_on);
		cyc(400);
		chk("sw", 8'h5A, switch_on);
		transfer_error = 1;
		cyc(4);
		u_host.xfer(8, 32'hFF, q);
		cyc(8);
		chk("hold", 8'h5A, switch_on);
		chk("fpin", 1, fault_n_oe);
		transfer_error = 0;
		out_enable = 0;
		cyc(50);
		chk("sw", 0, switch_on);
		chk("sdo", 0, sdo);
		out_enable = 1;
		cyc(60);
		chk("sw", 0, switch_on);
		overheat_diag = 8'h00;
		u_host.xfer(8, 32'h3C, q);
		cyc(8);
		chk("sw", 8'h3C, switch_on);
		fork
			u_host.hold(300);
			begin
				cyc(280);
				chk("wd", 0, switch_on);
			end
		join
		u_host.xfer(9, 32'h1FF, q);
		cyc(8);
		chk("ferr", 1, fault_n_oe);
		undervoltage_lockout = 1;
		cyc(80);
		chk("pg", 1, supply_ok_flag_oe);
		undervoltage_lockout = 0;
		cyc(80);
		chk("pg", 0, supply_ok_flag_oe);
		chk("fout", 0, fault_n_out);
		chk("pout", 0, supply_ok_flag_out);
		conclude;
	end
endmodule
`default_nettype wire
